// ### sdm_cfg.svh
// Constants for the receive-mode select and lock-status block
`ifndef SDM_CFG_SVH
`define SDM_CFG_SVH

// Register byte offsets
`define SDM_ADDR_W 4
`define SDM_OFS_CTRL 4'h0
`define SDM_OFS_STATUS 4'h4
`define SDM_OFS_IRQ_STAT 4'h8
`define SDM_OFS_IRQ_MASK 4'hc

// Control register fields
`define SDM_CTRL_OUT_EN 0
`define SDM_CTRL_RST 1'h1

// Status register fields
`define SDM_ST_LOCKED 0
`define SDM_ST_AUTO 1
`define SDM_ST_MODE_LO 2
`define SDM_ST_MODE_HI 3
`define SDM_ST_ASI_PIN 4
`define SDM_ST_VID_PIN 5

// Interrupt status and mask fields
`define SDM_IRQ_W 3
`define SDM_IRQ_LOCK_UP 0
`define SDM_IRQ_LOCK_DOWN 1
`define SDM_IRQ_MODE_CHG 2
`define SDM_IRQ_RST 3'h0

// Bus answers
`define SDM_RESP_OKAY 2'h0
`define SDM_RESP_SLVERR 2'h2

// Datapath width and pixel clock rate
`define SDM_DATA_W 10
`define SDM_PCLK_HZ 27000000
`define SDM_SYNC_W 3

// Positions of the synchronised pins in the sync vector
`define SDM_PIN_AUTO 2
`define SDM_PIN_ASI 1
`define SDM_PIN_VID 0

`endif

// ### sdm_pkg.sv
// Types for the receive-mode select and lock-status block
`default_nettype none
`include "sdm_cfg.svh"
package sdm_pkg;

  // Receive mode the block is operating in
  typedef enum logic [1:0] {
    SDM_MODE_NONE = 2'b00,
    SDM_MODE_ASI = 2'b01,
    SDM_MODE_SMPTE = 2'b10,
    SDM_MODE_THRU = 2'b11
  } sdm_mode_t;

  // Lock indications from the deserializer datapath
  typedef struct packed {
    logic smpte;
    logic asi;
    logic reclk;
  } sdm_lock_t;

  // Feature enables handed to the datapath
  typedef struct packed {
    logic asi_dec;
    logic smpte_dec;
    logic video_feat;
    logic thru;
  } sdm_feat_t;

  // Register selected by a bus address
  typedef enum logic [2:0] {
    SDM_REG_CTRL = 3'b000,
    SDM_REG_STATUS = 3'b001,
    SDM_REG_IRQ_STAT = 3'b010,
    SDM_REG_IRQ_MASK = 3'b011,
    SDM_REG_NONE = 3'b100
  } sdm_reg_t;

endpackage : sdm_pkg
`default_nettype wire

// ### sdm_sync.sv
// Two-stage synchroniser for asynchronous control pins
`timescale 1ns/1ps
`default_nettype none
module sdm_sync #(
  parameter int WIDTH = 1
) (
  // Clock, enable and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Raw and synchronised levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // One flop pair per bit; the first stage feeds only the second
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic meta_q;
      logic stab_q;
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          meta_q <= 1'b0;
          stab_q <= 1'b0;
        end
        else if (ce)
        begin
          meta_q <= async_i[g];
          stab_q <= meta_q;
        end
      end
      assign sync_o[g] = stab_q;
    end
  endgenerate

endmodule : sdm_sync
`default_nettype wire

// ### sdm_mode_lock.sv
// Receive-mode select, lock status and output gating with register slave
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sdm_cfg.svh"

// Overview of operation
// - Lock is high when locked in the chosen mode, otherwise low.
// - While unlocked every digital output is held low; the code gates only dig_o, while pclk_o keeps toggling and irq_o can be high.
// - Detect-select high: automatic mode, both mode pins driven as status.
// - Automatic: ASI mode pin high only while locked to ASI.
// - Automatic: video mode pin high only while locked to SMPTE.
// - Automatic: video pin low means no video features.
// - Detect-select low: manual mode, both mode pins are inputs.
// - Manual: ASI pin high selects ASI and ignores the video pin.
// - Manual: ASI pin low means no 8b/10b decode or ASI alignment.
// - Manual: video high, ASI low selects SMPTE with video features.
// - Manual: video pin low means no SMPTE decode and no video features.
// - Manual: other data is still reclocked, data-through operation.
// - A pixel clock output is given; lock is synchronous to it.
module sdm_mode_lock (
  // Clock, enable and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Mode pins
  input wire logic detect_select,
  input wire logic asi_mode_pin_i,
  output logic asi_mode_pin_o,
  output logic asi_mode_pin_oe,
  input wire logic video_mode_pin_i,
  output logic video_mode_pin_o,
  output logic video_mode_pin_oe,
  // Datapath side
  input wire sdm_pkg::sdm_lock_t lock_i,
  input wire logic [`SDM_DATA_W-1:0] dig_i,
  output logic [`SDM_DATA_W-1:0] dig_o,
  output sdm_pkg::sdm_feat_t feat_o,
  output logic locked_o,
  output logic pclk_o,
  output logic irq_o,
  // AXI4-Lite slave
  input wire logic awvalid,
  output logic awready,
  input wire logic [`SDM_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [`SDM_ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  import sdm_pkg::*;

  // Map a byte address to a register
  function automatic sdm_reg_t reg_sel(input logic [`SDM_ADDR_W-1:0] a);
    unique case (a)
      `SDM_OFS_CTRL: reg_sel = SDM_REG_CTRL;
      `SDM_OFS_STATUS: reg_sel = SDM_REG_STATUS;
      `SDM_OFS_IRQ_STAT: reg_sel = SDM_REG_IRQ_STAT;
      `SDM_OFS_IRQ_MASK: reg_sel = SDM_REG_IRQ_MASK;
      default: reg_sel = SDM_REG_NONE;
    endcase
  endfunction : reg_sel

  logic [`SDM_SYNC_W-1:0] raw_s;
  logic [`SDM_SYNC_W-1:0] pin_s;
  logic auto_s;
  logic asi_s;
  logic vid_s;
  sdm_mode_t mode_d;
  sdm_mode_t mode_q;
  logic locked_d;
  logic locked_q;
  logic auto_q;
  sdm_feat_t feat_d;
  logic ctrl_out_en_q;
  logic [`SDM_IRQ_W-1:0] irq_stat_q;
  logic [`SDM_IRQ_W-1:0] irq_mask_q;
  logic [`SDM_IRQ_W-1:0] irq_evt;
  logic [`SDM_IRQ_W-1:0] irq_clr;
  logic aw_held_q;
  logic w_held_q;
  logic [`SDM_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go;
  sdm_reg_t wr_sel;
  logic [31:0] status_word;

  // Asynchronous control pins pass two flops
  assign raw_s = {detect_select, asi_mode_pin_i, video_mode_pin_i};
  sdm_sync #(.WIDTH(`SDM_SYNC_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .async_i(raw_s),
    .sync_o(pin_s)
  );
  assign auto_s = pin_s[`SDM_PIN_AUTO];
  assign asi_s = pin_s[`SDM_PIN_ASI];
  assign vid_s = pin_s[`SDM_PIN_VID];

  // Mode decision and lock source
  always_comb
  begin
    if (auto_s)
    begin
      // Automatic: detection picks the stream, ASI takes priority
      if (lock_i.asi)
        mode_d = SDM_MODE_ASI;
      else if (lock_i.smpte)
        mode_d = SDM_MODE_SMPTE;
      else
        mode_d = SDM_MODE_NONE;
    end
    else if (asi_s)
      mode_d = SDM_MODE_ASI;
    else if (vid_s)
      mode_d = SDM_MODE_SMPTE;
    else
      mode_d = SDM_MODE_THRU;
    unique case (mode_d)
      SDM_MODE_ASI: locked_d = lock_i.asi;
      SDM_MODE_SMPTE: locked_d = lock_i.smpte;
      SDM_MODE_THRU: locked_d = lock_i.reclk;
      SDM_MODE_NONE: locked_d = 1'b0;
    endcase
  end

  // Feature enables; automatic mode keeps both decoders hunting
  always_comb
  begin
    feat_d.asi_dec = auto_s || (mode_d == SDM_MODE_ASI);
    feat_d.smpte_dec = auto_s || (mode_d == SDM_MODE_SMPTE);
    feat_d.video_feat = (mode_d == SDM_MODE_SMPTE);
    feat_d.thru = (mode_d == SDM_MODE_THRU);
  end

  // Mode, lock, pin drive and gated outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_q <= SDM_MODE_NONE;
      locked_q <= 1'b0;
      auto_q <= 1'b0;
      feat_o <= '0;
      asi_mode_pin_o <= 1'b0;
      video_mode_pin_o <= 1'b0;
      asi_mode_pin_oe <= 1'b0;
      video_mode_pin_oe <= 1'b0;
      dig_o <= '0;
    end
    else if (ce)
    begin
      mode_q <= mode_d;
      locked_q <= locked_d;
      auto_q <= auto_s;
      feat_o <= feat_d;
      asi_mode_pin_oe <= auto_s;
      video_mode_pin_oe <= auto_s;
      asi_mode_pin_o <= auto_s && (mode_d == SDM_MODE_ASI);
      video_mode_pin_o <= auto_s && (mode_d == SDM_MODE_SMPTE);
      dig_o <= (locked_d && ctrl_out_en_q) ? dig_i : '0;
    end
  end
  assign locked_o = locked_q;

  // Pixel clock output, a toggle of the core clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pclk_o <= 1'b0;
    else if (ce)
      pclk_o <= !pclk_o;
  end

  // Write channel: address and data are taken in either order
  assign awready = !aw_held_q && !bvalid;
  assign wready = !w_held_q && !bvalid;
  assign wr_go = aw_held_q && w_held_q && !bvalid;
  assign wr_sel = reg_sel(awaddr_q);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid <= 1'b0;
      bresp <= `SDM_RESP_OKAY;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_held_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_go)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (wr_sel == SDM_REG_NONE) ? `SDM_RESP_SLVERR : `SDM_RESP_OKAY;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // Control and mask registers, low byte lane only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_out_en_q <= `SDM_CTRL_RST;
      irq_mask_q <= `SDM_IRQ_RST;
    end
    else if (ce && wr_go && wstrb_q[0])
    begin
      if (wr_sel == SDM_REG_CTRL)
        ctrl_out_en_q <= wdata_q[`SDM_CTRL_OUT_EN];
      if (wr_sel == SDM_REG_IRQ_MASK)
        irq_mask_q <= wdata_q[`SDM_IRQ_W-1:0];
    end
  end

  // Sticky events, cleared by writing one; a new event wins
  assign irq_evt[`SDM_IRQ_LOCK_UP] = locked_d && !locked_q;
  assign irq_evt[`SDM_IRQ_LOCK_DOWN] = !locked_d && locked_q;
  assign irq_evt[`SDM_IRQ_MODE_CHG] = mode_d != mode_q;
  assign irq_clr = (wr_go && wstrb_q[0] && wr_sel == SDM_REG_IRQ_STAT) ?
    wdata_q[`SDM_IRQ_W-1:0] : '0;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat_q <= `SDM_IRQ_RST;
    else if (ce)
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
  end
  assign irq_o = |(irq_stat_q & irq_mask_q);

  // Read channel answers one cycle after the address is taken
  always_comb
  begin
    status_word = '0;
    status_word[`SDM_ST_LOCKED] = locked_q;
    status_word[`SDM_ST_AUTO] = auto_q;
    status_word[`SDM_ST_MODE_HI:`SDM_ST_MODE_LO] = mode_q;
    status_word[`SDM_ST_ASI_PIN] = asi_s;
    status_word[`SDM_ST_VID_PIN] = vid_s;
  end
  assign arready = !rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `SDM_RESP_OKAY;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rresp <= `SDM_RESP_OKAY;
        unique case (reg_sel(araddr))
          SDM_REG_CTRL: rdata <= {31'h0, ctrl_out_en_q};
          SDM_REG_STATUS: rdata <= status_word;
          SDM_REG_IRQ_STAT: rdata <= {29'h0, irq_stat_q};
          SDM_REG_IRQ_MASK: rdata <= {29'h0, irq_mask_q};
          SDM_REG_NONE:
          begin
            rdata <= '0;
            rresp <= `SDM_RESP_SLVERR;
          end
        endcase
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

  // Checks on mode selection and lock behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_auto;
    ce && auto_s;
  endsequence
  sequence s_manual;
    ce && !auto_s;
  endsequence

  property p_lock_thru;
    s_manual ##0 (!asi_s && !vid_s && lock_i.reclk) |=> locked_q;
  endproperty
  a_lock_thru: assert property (p_lock_thru) else $error("lock lost in data-through");

  property p_gate;
    !locked_q |-> dig_o == '0;
  endproperty
  a_gate: assert property (p_gate) else $error("output not forced low");

  property p_auto_drive;
    s_auto |=> asi_mode_pin_oe && video_mode_pin_oe;
  endproperty
  a_auto_drive: assert property (p_auto_drive) else $error("auto pins not driven");

  property p_auto_asi;
    s_auto ##0 lock_i.asi |=> asi_mode_pin_o && !video_mode_pin_o;
  endproperty
  a_auto_asi: assert property (p_auto_asi) else $error("asi pin wrong");

  property p_auto_vid;
    s_auto ##0 !lock_i.smpte |=> !video_mode_pin_o;
  endproperty
  a_auto_vid: assert property (p_auto_vid) else $error("video pin high unlocked");

  property p_no_feat;
    auto_q && !video_mode_pin_o |-> !feat_o.video_feat;
  endproperty
  a_no_feat: assert property (p_no_feat) else $error("video feature on");

  property p_man_input;
    s_manual |=> !asi_mode_pin_oe && !video_mode_pin_oe;
  endproperty
  a_man_input: assert property (p_man_input) else $error("manual pin driven");

  property p_man_asi;
    s_manual ##0 asi_s |=> mode_q == SDM_MODE_ASI && !feat_o.video_feat;
  endproperty
  a_man_asi: assert property (p_man_asi) else $error("asi not chosen");

  property p_man_no_asi;
    s_manual ##0 !asi_s |=> !feat_o.asi_dec;
  endproperty
  a_man_no_asi: assert property (p_man_no_asi) else $error("asi decode on");

  property p_man_smpte;
    s_manual ##0 (vid_s && !asi_s) |=> feat_o.video_feat && feat_o.smpte_dec;
  endproperty
  a_man_smpte: assert property (p_man_smpte) else $error("smpte not chosen");

  property p_man_no_vid;
    s_manual ##0 !vid_s |=> !feat_o.smpte_dec && !feat_o.video_feat;
  endproperty
  a_man_no_vid: assert property (p_man_no_vid) else $error("smpte decode on");

  property p_thru;
    s_manual ##0 (!vid_s && !asi_s) |=> feat_o.thru && mode_q == SDM_MODE_THRU;
  endproperty
  a_thru: assert property (p_thru) else $error("data-through not chosen");

  property p_pclk;
    ce |=> pclk_o != $past(pclk_o);
  endproperty
  a_pclk: assert property (p_pclk) else $error("pixel clock stuck");

  property p_sync;
    $past(ce) && $past(ce, 2) |-> auto_s == $past(detect_select, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("select sync depth wrong");

endmodule : sdm_mode_lock
`default_nettype wire

// ### sdm_ctl_model.sv
// Controller model that drives the mode pins in manual mode
`timescale 1ns/1ps
`default_nettype none
module sdm_ctl_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Controller requests
  input wire logic detect_select,
  input wire logic asi_lvl,
  input wire logic video_lvl,
  // Device pin side
  input wire logic asi_mode_pin_o,
  input wire logic asi_mode_pin_oe,
  input wire logic video_mode_pin_o,
  input wire logic video_mode_pin_oe,
  output logic asi_mode_pin_i,
  output logic video_mode_pin_i
);
  logic float_q;
  logic drive;

  // A released pin shows a pattern that changes every cycle
  always_ff @(posedge aclk)
    float_q <= aresetn ? ~float_q : 1'b0;

  // Controller drives the pins only in manual mode
  assign drive = ~detect_select;
  // Wire level from both parties' enables
  assign asi_mode_pin_i = asi_mode_pin_oe ? asi_mode_pin_o :
    (drive ? asi_lvl : float_q);
  assign video_mode_pin_i = video_mode_pin_oe ? video_mode_pin_o :
    (drive ? video_lvl : ~float_q);
endmodule : sdm_ctl_model
`default_nettype wire

// ### tb.sv
// Testbench for the receive-mode select and lock-status block
`timescale 1ns/1ps
`default_nettype none
`include "sdm_cfg.svh"
module tb;
  import sdm_pkg::*;
  logic aclk, aresetn, ce, detect_select, asi_lvl, video_lvl, p0;
  logic asi_mode_pin_i, asi_mode_pin_o, asi_mode_pin_oe;
  logic video_mode_pin_i, video_mode_pin_o, video_mode_pin_oe;
  sdm_lock_t lock_i, l;
  logic [`SDM_DATA_W-1:0] dig_i, dig_o;
  sdm_feat_t feat_o;
  logic locked_o, pclk_o, irq_o;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  int num_errors = 0;
  int n_tests = 0;
  // Manual cases: pins {asi,video}, lock that counts, features, mode
  logic [1:0] pins [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
  sdm_lock_t want [4] = '{3'b010, 3'b010, 3'b100, 3'b001};
  sdm_feat_t feat_x [4] = '{4'b1000, 4'b1000, 4'b0110, 4'b0001};
  logic [1:0] mode_x [4] = '{2'h1, 2'h1, 2'h2, 2'h3};

  sdm_mode_lock sdm_mode_lock_inst (.aclk, .aresetn, .ce, .detect_select,
    .asi_mode_pin_i, .asi_mode_pin_o, .asi_mode_pin_oe, .video_mode_pin_i,
    .video_mode_pin_o, .video_mode_pin_oe, .lock_i, .dig_i, .dig_o, .feat_o,
    .locked_o, .pclk_o, .irq_o, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp);

  sdm_ctl_model sdm_ctl_model_inst (.aclk, .aresetn, .detect_select, .asi_lvl,
    .video_lvl, .asi_mode_pin_o, .asi_mode_pin_oe, .video_mode_pin_o,
    .video_mode_pin_oe, .asi_mode_pin_i, .video_mode_pin_i);

  // Clock at 25 MHz
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Write one word; both channels offered together, response kept in rsp
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      aw_ok = aw_ok | (awready === 1'b1);
      w_ok = w_ok | (wready === 1'b1);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
    // One edge passes so a following call never reassigns bready in one step
    @(posedge aclk);
  endtask : axi_wr

  // Read one word into rd, response into rsp
  task automatic axi_rd(input logic [3:0] a);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    // One edge passes so a following call never reassigns rready in one step
    @(posedge aclk);
  endtask : axi_rd

  task automatic report_and_stop;
    $display("Errors %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    {aresetn, ce, detect_select, asi_lvl, video_lvl} = 5'b01000;
    {awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
    {awaddr, araddr, wdata, wstrb} = {8'h00, 32'h0, 4'hf};
    lock_i = 3'b000;
    dig_i = 10'h2a5;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values and an unmapped place
    axi_rd(`SDM_OFS_CTRL);
    chk("ctrl reset", rd, 32'h1);
    axi_rd(`SDM_OFS_IRQ_MASK);
    chk("mask reset", rd, 32'h0);
    axi_rd(4'h6);
    chk("unmapped read resp", rsp, `SDM_RESP_SLVERR);
    chk("unmapped read data", rd, 32'h0);
    axi_wr(4'h2, 32'h1);
    chk("unmapped write resp", rsp, `SDM_RESP_SLVERR);
    // Manual mode: every pin combination, with and without the right lock
    for (int i = 0; i < 4; i++)
    begin
      {asi_lvl, video_lvl} <= pins[i];
      lock_i <= want[i];
      repeat (5) @(posedge aclk);
      chk("manual locked", locked_o, 1'b1);
      chk("manual feat", feat_o, feat_x[i]);
      chk("manual dig", dig_o, dig_i);
      chk("manual oe", {asi_mode_pin_oe, video_mode_pin_oe}, 2'b00);
      axi_rd(`SDM_OFS_STATUS);
      chk("status mode", rd[3:0], {mode_x[i], 2'b01});
      lock_i <= ~want[i];
      repeat (3) @(posedge aclk);
      chk("manual unlocked", locked_o, 1'b0);
      chk("unlocked dig", dig_o, 10'h000);
    end
    // Pin change passes two flops before use
    lock_i <= 3'b011;
    repeat (3) @(posedge aclk);
    {asi_lvl, video_lvl} <= 2'b10;
    repeat (3) @(posedge aclk);
    chk("sync old", feat_o, 4'b0001);
    @(posedge aclk);
    chk("sync new", feat_o, 4'b1000);
    // Output enable in the control register
    axi_wr(`SDM_OFS_CTRL, 32'h0);
    repeat (2) @(posedge aclk);
    chk("out_en off", dig_o, 10'h000);
    axi_wr(`SDM_OFS_CTRL, 32'h1);
    repeat (2) @(posedge aclk);
    chk("out_en on", dig_o, dig_i);
    // Automatic mode: each lock kind
    detect_select <= 1'b1;
    for (int j = 0; j < 4; j++)
    begin
      l = (j == 3) ? 3'b110 : 3'b001 << j;
      lock_i <= l;
      repeat (5) @(posedge aclk);
      chk("auto oe", {asi_mode_pin_oe, video_mode_pin_oe}, 2'b11);
      chk("auto pins", {asi_mode_pin_o, video_mode_pin_o}, {l.asi, l.smpte & ~l.asi});
      chk("auto locked", locked_o, l.asi | l.smpte);
      chk("auto video feat", feat_o.video_feat, l.smpte & ~l.asi);
    end
    // Interrupt: raise, mask, clear
    lock_i <= 3'b000;
    repeat (5) @(posedge aclk);
    axi_wr(`SDM_OFS_IRQ_STAT, 32'h7);
    axi_wr(`SDM_OFS_IRQ_MASK, 32'h1);
    chk("irq idle", irq_o, 1'b0);
    lock_i <= 3'b010;
    repeat (3) @(posedge aclk);
    chk("irq on rise", irq_o, 1'b1);
    axi_rd(`SDM_OFS_IRQ_STAT);
    chk("stat rise", rd, 32'h5);
    axi_wr(`SDM_OFS_IRQ_STAT, 32'h1);
    chk("irq cleared", irq_o, 1'b0);
    lock_i <= 3'b000;
    repeat (3) @(posedge aclk);
    chk("irq masked", irq_o, 1'b0);
    axi_rd(`SDM_OFS_IRQ_STAT);
    chk("stat fall", rd, 32'h6);
    axi_wr(`SDM_OFS_IRQ_MASK, 32'h2);
    chk("irq on fall", irq_o, 1'b1);
    axi_wr(`SDM_OFS_IRQ_STAT, 32'h7);
    chk("irq all clear", irq_o, 1'b0);
    // Pixel clock toggles every edge
    p0 = pclk_o;
    @(posedge aclk);
    chk("pclk toggle", pclk_o, {~p0});
    // Clock enable low freezes the pixel clock after its last toggle
    ce <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("ce freeze", pclk_o, p0);
    ce <= 1'b1;
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
